// ===== hdl/pcw_pkg.sv
// Contract
// - A host cycle to a window whose enable bit is 0 is never claimed.
// - After reset every window is disabled; the enable register reads zero.
// - Enable bit 7 opens I/O window 1, bit 6 opens I/O window 0.
// - Enable bits 4 to 0 open memory windows 4 to 0.
// - Enable bit 5 is reserved, reads 0, writes ignored.
// - Extend bits 7 and 3 add one wait state to 16-bit I/O cycles only.
// - Fast bits 6 and 2 shorten 8-bit I/O cycles only.
// - Width-from-card bits 5 and 1 let the card width pin choose width.
// - Wide bits 4 and 0 pick 8 or 16 bits unless width-from-card is set.
// - Start low byte registers hold start address bits 7 to 0, reset zero.
// - Registers sit at base 800h plus index; second socket shifted by 40h.
// - The I/O control register resets to 00h.
// - Start high bytes hold address bits 15 to 8 at 09h and 0Dh.
// - End addresses are low/high bytes at 0Ah/0Bh and 0Eh/0Fh.
`default_nettype none
package pcw_pkg;
    localparam logic [11:0] SOCK_BASE      = 12'h800;
    localparam logic [11:0] SOCK_STRIDE    = 12'h040;
    localparam logic [5:0]  IDX_WIN_EN     = 6'h06;
    localparam logic [5:0]  IDX_IO_CTRL    = 6'h07;
    localparam logic [5:0]  IDX_IO0_ST_LO  = 6'h08;
    localparam logic [5:0]  IDX_IO0_ST_HI  = 6'h09;
    localparam logic [5:0]  IDX_IO0_END_LO = 6'h0A;
    localparam logic [5:0]  IDX_IO0_END_HI = 6'h0B;
    localparam logic [5:0]  IDX_IO1_ST_LO  = 6'h0C;
    localparam logic [5:0]  IDX_IO1_ST_HI  = 6'h0D;
    localparam logic [5:0]  IDX_IO1_END_LO = 6'h0E;
    localparam logic [5:0]  IDX_IO1_END_HI = 6'h0F;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam logic [7:0]  WIN_EN_WMASK   = 8'hDF;
    localparam int          BIT_IO1_EN     = 7;
    localparam int          BIT_IO0_EN     = 6;
    localparam int          BIT_RESERVED_BIT5       = 5;
    localparam int          MEM_WINS       = 5;
    localparam int          BIT_IO1_EXT    = 7;
    localparam int          BIT_IO1_FAST   = 6;
    localparam int          BIT_IO1_CARD   = 5;
    localparam int          BIT_IO1_WIDE   = 4;
    localparam int          BIT_IO0_EXT    = 3;
    localparam int          BIT_IO0_FAST   = 2;
    localparam int          BIT_IO0_CARD   = 1;
    localparam int          BIT_IO0_WIDE   = 0;

    typedef enum logic [1:0] {
        CYC_STD,
        CYC_EXT16,
        CYC_FAST8
    } pcw_cyc_t;
endpackage : pcw_pkg
`default_nettype wire

// ===== hdl/pcw_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcw_cfg_if;
    logic [7:0]       winEnable;
    logic [7:0]       ioCtrl;
    logic [15:0]      ioStart0;
    logic [15:0]      ioEnd0;
    logic [15:0]      ioStart1;
    logic [15:0]      ioEnd1;
    logic [15:0]      ioAddr;
    logic             cardWide;
    logic             hit;
    logic             winOne;
    logic             wide;
    pcw_pkg::pcw_cyc_t cycle;

    modport regs (output winEnable, ioCtrl, ioStart0, ioEnd0, ioStart1, ioEnd1, ioAddr, cardWide,
                  input hit, winOne, wide, cycle);
    modport dec  (input winEnable, ioCtrl, ioStart0, ioEnd0, ioStart1, ioEnd1, ioAddr, cardWide,
                  output hit, winOne, wide, cycle);
endinterface : pcw_cfg_if
`default_nettype wire

// ===== hdl/pcw_io_decode.sv
`timescale 1ns/1ps
`default_nettype none
module pcw_io_decode (
    // Configuration and result
    pcw_cfg_if.dec cfg
);
    function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction : inRange

    logic hit0;
    logic hit1;
    logic useOne;
    logic wideSel;
    logic extSel;
    logic fastSel;

    // Window 0 wins when both windows overlap, so the outcome stays predictable.
    always_comb begin
        hit0    = cfg.winEnable[pcw_pkg::BIT_IO0_EN] && inRange(cfg.ioAddr, cfg.ioStart0, cfg.ioEnd0);
        hit1    = cfg.winEnable[pcw_pkg::BIT_IO1_EN] && inRange(cfg.ioAddr, cfg.ioStart1, cfg.ioEnd1);
        useOne  = hit1 && !hit0;
        if (useOne) begin
            wideSel = cfg.ioCtrl[pcw_pkg::BIT_IO1_CARD] ? cfg.cardWide : cfg.ioCtrl[pcw_pkg::BIT_IO1_WIDE];
            extSel  = cfg.ioCtrl[pcw_pkg::BIT_IO1_EXT];
            fastSel = cfg.ioCtrl[pcw_pkg::BIT_IO1_FAST];
        end else begin
            wideSel = cfg.ioCtrl[pcw_pkg::BIT_IO0_CARD] ? cfg.cardWide : cfg.ioCtrl[pcw_pkg::BIT_IO0_WIDE];
            extSel  = cfg.ioCtrl[pcw_pkg::BIT_IO0_EXT];
            fastSel = cfg.ioCtrl[pcw_pkg::BIT_IO0_FAST];
        end
        cfg.hit    = hit0 || hit1;
        cfg.winOne = useOne;
        cfg.wide   = wideSel;
        if (wideSel) begin
            cfg.cycle = extSel ? pcw_pkg::CYC_EXT16 : pcw_pkg::CYC_STD;
        end else begin
            cfg.cycle = fastSel ? pcw_pkg::CYC_FAST8 : pcw_pkg::CYC_STD;
        end
    end
endmodule : pcw_io_decode
`default_nettype wire

// ===== hdl/pcw_window_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pcw_window_regs #(
    parameter bit SOCKET = 1'b0
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Register access
    input  wire logic [11:0]       regAddr,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [7:0]        regWdata,
    output logic      [7:0]        regRdata,
    output logic                   regRdValid,
    // Memory cycles
    input  wire logic              memReq,
    input  wire logic [4:0]        memWinMatch,
    output logic                   memClaim,
    // I/O cycles
    input  wire logic              ioReq,
    input  wire logic [15:0]       ioAddr,
    input  wire logic              cardIois16,
    output logic                   ioClaim,
    output logic                   ioWinOne,
    output logic                   ioWide,
    output pcw_pkg::pcw_cyc_t      ioCycle
);
    localparam logic [11:0] SOCK_ADDR = pcw_pkg::SOCK_BASE + (SOCKET ? pcw_pkg::SOCK_STRIDE : 12'h000);

    logic [7:0]  winEn_reg;
    logic [7:0]  ioCtrl_reg;
    logic [7:0]  stLo_reg  [2];
    logic [7:0]  stHi_reg  [2];
    logic [7:0]  endLo_reg [2];
    logic [7:0]  endHi_reg [2];
    logic [7:0]  regRdata_next;
    logic        sockHit;
    logic [5:0]  idx;
    logic        iois16Meta_reg;
    logic        iois16Sync_reg;
    logic        memClaim_reg;
    logic        ioClaim_reg;
    logic        ioWinOne_reg;
    logic        ioWide_reg;
    pcw_pkg::pcw_cyc_t ioCycle_reg;
    logic        regRdValid_reg;
    logic [7:0]  regRdata_reg;

    pcw_cfg_if cfg ();

    assign sockHit = (regAddr[11:6] == SOCK_ADDR[11:6]);
    assign idx     = regAddr[5:0];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            winEn_reg <= pcw_pkg::REG_RESET;
        end else if (regWrite && sockHit && idx == pcw_pkg::IDX_WIN_EN) begin
            winEn_reg <= regWdata & pcw_pkg::WIN_EN_WMASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ioCtrl_reg <= pcw_pkg::REG_RESET;
        end else if (regWrite && sockHit && idx == pcw_pkg::IDX_IO_CTRL) begin
            ioCtrl_reg <= regWdata;
        end
    end

    // Both I/O windows share one layout, four indexes apart.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int w = 0; w < 2; w++) begin
                stLo_reg[w]  <= pcw_pkg::REG_RESET;
                stHi_reg[w]  <= pcw_pkg::REG_RESET;
                endLo_reg[w] <= pcw_pkg::REG_RESET;
                endHi_reg[w] <= pcw_pkg::REG_RESET;
            end
        end else if (regWrite && sockHit) begin
            unique case (idx)
                pcw_pkg::IDX_IO0_ST_LO:  stLo_reg[0]  <= regWdata;
                pcw_pkg::IDX_IO0_ST_HI:  stHi_reg[0]  <= regWdata;
                pcw_pkg::IDX_IO0_END_LO: endLo_reg[0] <= regWdata;
                pcw_pkg::IDX_IO0_END_HI: endHi_reg[0] <= regWdata;
                pcw_pkg::IDX_IO1_ST_LO:  stLo_reg[1]  <= regWdata;
                pcw_pkg::IDX_IO1_ST_HI:  stHi_reg[1]  <= regWdata;
                pcw_pkg::IDX_IO1_END_LO: endLo_reg[1] <= regWdata;
                pcw_pkg::IDX_IO1_END_HI: endHi_reg[1] <= regWdata;
                default: ;
            endcase
        end
    end

    // Unmapped indexes read as zero so software probing sees a quiet socket.
    always_comb begin
        regRdata_next = 8'h00;
        unique case (idx)
            pcw_pkg::IDX_WIN_EN:     regRdata_next = winEn_reg & pcw_pkg::WIN_EN_WMASK;
            pcw_pkg::IDX_IO_CTRL:    regRdata_next = ioCtrl_reg;
            pcw_pkg::IDX_IO0_ST_LO:  regRdata_next = stLo_reg[0];
            pcw_pkg::IDX_IO0_ST_HI:  regRdata_next = stHi_reg[0];
            pcw_pkg::IDX_IO0_END_LO: regRdata_next = endLo_reg[0];
            pcw_pkg::IDX_IO0_END_HI: regRdata_next = endHi_reg[0];
            pcw_pkg::IDX_IO1_ST_LO:  regRdata_next = stLo_reg[1];
            pcw_pkg::IDX_IO1_ST_HI:  regRdata_next = stHi_reg[1];
            pcw_pkg::IDX_IO1_END_LO: regRdata_next = endLo_reg[1];
            pcw_pkg::IDX_IO1_END_HI: regRdata_next = endHi_reg[1];
            default:                 regRdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regRdValid_reg <= 1'b0;
            regRdata_reg   <= pcw_pkg::REG_RESET;
        end else begin
            regRdValid_reg <= regRead && sockHit;
            regRdata_reg   <= (regRead && sockHit) ? regRdata_next : pcw_pkg::REG_RESET;
        end
    end

    // The card width pin is asynchronous to the host clock.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            iois16Meta_reg <= 1'b0;
            iois16Sync_reg <= 1'b0;
        end else begin
            iois16Meta_reg <= cardIois16;
            iois16Sync_reg <= iois16Meta_reg;
        end
    end

    assign cfg.winEnable = winEn_reg;
    assign cfg.ioCtrl    = ioCtrl_reg;
    assign cfg.ioStart0  = {stHi_reg[0], stLo_reg[0]};
    assign cfg.ioEnd0    = {endHi_reg[0], endLo_reg[0]};
    assign cfg.ioStart1  = {stHi_reg[1], stLo_reg[1]};
    assign cfg.ioEnd1    = {endHi_reg[1], endLo_reg[1]};
    assign cfg.ioAddr    = ioAddr;
    assign cfg.cardWide  = iois16Sync_reg;

    pcw_io_decode u_decode (
        .cfg (cfg.dec)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            memClaim_reg <= 1'b0;
        end else begin
            memClaim_reg <= memReq && |(memWinMatch & winEn_reg[pcw_pkg::MEM_WINS-1:0]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ioClaim_reg  <= 1'b0;
            ioWinOne_reg <= 1'b0;
            ioWide_reg   <= 1'b0;
            ioCycle_reg  <= pcw_pkg::CYC_STD;
        end else begin
            ioClaim_reg  <= ioReq && cfg.hit;
            ioWinOne_reg <= cfg.winOne;
            ioWide_reg   <= cfg.wide;
            ioCycle_reg  <= cfg.cycle;
        end
    end

    assign regRdata   = regRdata_reg;
    assign regRdValid = regRdValid_reg;
    assign memClaim   = memClaim_reg;
    assign ioClaim    = ioClaim_reg;
    assign ioWinOne   = ioWinOne_reg;
    assign ioWide     = ioWide_reg;
    assign ioCycle    = ioCycle_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence sWriteEn;
        regWrite && sockHit && idx == pcw_pkg::IDX_WIN_EN;
    endsequence
    sequence sReadEn;
        regRead && sockHit && idx == pcw_pkg::IDX_WIN_EN;
    endsequence
    sequence sReadBack;
        regRdValid && regRdata == $past(winEn_reg);
    endsequence

    a_mem_claim_gate: assert property (memClaim |-> $past(memReq && |(memWinMatch & winEn_reg[4:0])))
        else $error("Memory cycle claimed for a disabled window.");
    a_io_claim_gate: assert property (ioClaim |-> $past(ioReq && (winEn_reg[7] || winEn_reg[6])))
        else $error("I/O cycle claimed with both I/O windows disabled.");
    // This check keeps its own disable so that it still looks in the cycle after reset.
    a_reset_clear: assert property (disable iff (1'b0) rst |=>
        winEn_reg == pcw_pkg::REG_RESET && ioCtrl_reg == pcw_pkg::REG_RESET && !memClaim && !ioClaim)
        else $error("Registers not cleared by reset.");
    a_reserved_bit5_zero: assert property (winEn_reg[5] == 1'b0)
        else $error("Reserved enable bit became set.");
    a_en_write: assert property (sWriteEn |=> winEn_reg == ($past(regWdata) & pcw_pkg::WIN_EN_WMASK))
        else $error("Enable register write not stored.");
    a_en_readback: assert property (sReadEn |=> sReadBack)
        else $error("Enable register read back wrong.");
    a_other_socket: assert property (regRead && !sockHit |=> !regRdValid)
        else $error("Read outside the socket was answered.");
    a_start_lo_write: assert property (regWrite && sockHit && idx == pcw_pkg::IDX_IO0_ST_LO |=>
        stLo_reg[0] == $past(regWdata))
        else $error("Start low byte of window 0 not stored.");
    a_io0_range: assert property (ioClaim && !ioWinOne |->
        $past(winEn_reg[pcw_pkg::BIT_IO0_EN] && ioAddr >= cfg.ioStart0 && ioAddr <= cfg.ioEnd0))
        else $error("I/O claim outside window 0.");
    a_io1_range: assert property (ioClaim && ioWinOne |->
        $past(winEn_reg[pcw_pkg::BIT_IO1_EN] && ioAddr >= cfg.ioStart1 && ioAddr <= cfg.ioEnd1))
        else $error("I/O claim outside window 1.");
    a_ext_only_wide: assert property (ioCycle == pcw_pkg::CYC_EXT16 |-> ioWide)
        else $error("Extended cycle on a narrow access.");
    a_fast_only_narrow: assert property (ioCycle == pcw_pkg::CYC_FAST8 |-> !ioWide)
        else $error("Fast cycle on a wide access.");
    a_width_fixed: assert property (ioClaim && !ioWinOne && !$past(ioCtrl_reg[pcw_pkg::BIT_IO0_CARD]) |->
        ioWide == $past(ioCtrl_reg[pcw_pkg::BIT_IO0_WIDE]))
        else $error("Window 0 fixed width not applied.");
    a_width_card: assert property (ioClaim && !ioWinOne && $past(ioCtrl_reg[pcw_pkg::BIT_IO0_CARD]) |->
        ioWide == $past(iois16Sync_reg))
        else $error("Window 0 card width not applied.");
endmodule : pcw_window_regs
`default_nettype wire

// ===== sim/pcw_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcw_card_model (
    // Clock and command
    input  wire logic clk_sys,
    input  wire logic wantWide,
    // Card width pin
    output logic      cardIois16
);
    // The pin is asynchronous to the host, so it moves well clear of the sampling edge.
    initial cardIois16 = 1'b0;
    always @(posedge clk_sys) begin
        cardIois16 <= #7 wantWide;
    end
endmodule : pcw_card_model
`default_nettype wire

// ===== sim/pc_card_window_enable_io_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pc_card_window_enable_io_control_bench;
    logic              clk_sys     = 1'b0;
    logic              rst         = 1'b1;
    logic [11:0]       regAddr     = 12'h000;
    logic              regWrite    = 1'b0;
    logic              regRead     = 1'b0;
    logic [7:0]        regWdata    = 8'h00;
    logic [7:0]        regRdata;
    logic              regRdValid;
    logic              memReq      = 1'b0;
    logic [4:0]        memWinMatch = 5'h00;
    logic              memClaim;
    logic              ioReq       = 1'b0;
    logic [15:0]       ioAddr      = 16'h0000;
    logic              cardIois16;
    logic              wantWide    = 1'b0;
    logic              ioClaim;
    logic              ioWinOne;
    logic              ioWide;
    pcw_pkg::pcw_cyc_t ioCycle;
    int                fails       = 0;
    int                cmp_count   = 0;
    int                cycles      = 0;

    always #12.5 clk_sys = ~clk_sys;

    pcw_window_regs #(.SOCKET(1'b0)) uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid), .memReq(memReq),
        .memWinMatch(memWinMatch), .memClaim(memClaim), .ioReq(ioReq), .ioAddr(ioAddr), .cardIois16(cardIois16),
        .ioClaim(ioClaim), .ioWinOne(ioWinOne), .ioWide(ioWide), .ioCycle(ioCycle));
    pcw_card_model card (.clk_sys(clk_sys), .wantWide(wantWide), .cardIois16(cardIois16));

    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // The whole run needs well under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask : step

    // Every access leaves one idle edge so no strobe is lowered and raised in one step.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        step();
        regWrite = 1'b0;
        step();
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic v, input string msg);
        regAddr = a;
        regRead = 1'b1;
        step();
        regRead = 1'b0;
        check(regRdValid === v && regRdata === (v ? e : 8'h00), msg);
        step();
    endtask : rd

    task automatic mem(input logic [4:0] m, input logic c, input string msg);
        memWinMatch = m;
        memReq = 1'b1;
        step();
        memReq = 1'b0;
        check(memClaim === c, msg);
        step();
    endtask : mem

    task automatic io(input logic [15:0] a, input logic c, input logic w1, input logic wd,
                      input pcw_pkg::pcw_cyc_t cy, input string msg);
        ioAddr = a;
        ioReq = 1'b1;
        step();
        ioReq = 1'b0;
        check(ioClaim === c && (c === 1'b0 || (ioWinOne === w1 && ioWide === wd && ioCycle === cy)), msg);
        step();
    endtask : io

    // Nibble per window: extend, fast, width from card, wide.
    function automatic logic expWide(input logic [3:0] n, input logic cw);
        return n[1] ? cw : n[0];
    endfunction : expWide

    function automatic pcw_pkg::pcw_cyc_t expCyc(input logic [3:0] n, input logic cw);
        if (expWide(n, cw)) begin
            return n[3] ? pcw_pkg::CYC_EXT16 : pcw_pkg::CYC_STD;
        end
        return n[2] ? pcw_pkg::CYC_FAST8 : pcw_pkg::CYC_STD;
    endfunction : expCyc

    task automatic t_reset();
        rd(12'h806, 8'h00, 1'b1, "enable reset");
        rd(12'h807, 8'h00, 1'b1, "control reset");
        rd(12'h808, 8'h00, 1'b1, "start0 reset");
        rd(12'h80C, 8'h00, 1'b1, "start1 reset");
        rd(12'h83F, 8'h00, 1'b1, "unmapped read");
        rd(12'h846, 8'h00, 1'b0, "other socket read");
        mem(5'h1F, 1'b0, "mem claim after reset");
        io(16'h0000, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "io claim after reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_enable();
        wr(12'h806, 8'hFF);
        rd(12'h806, 8'hDF, 1'b1, "reserved bit reads zero");
        wr(12'h846, 8'h00);
        rd(12'h806, 8'hDF, 1'b1, "other socket write");
        for (int n = 0; n < 5; n++) begin
            wr(12'h806, 8'h1F ^ (8'h01 << n));
            mem(5'h01 << n, 1'b0, "disabled mem window");
            mem(5'h1F, 1'b1, "other mem windows");
            wr(12'h806, 8'h01 << n);
            mem(5'h01 << n, 1'b1, "enabled mem window");
        end
        $display("test enable done");
    endtask : t_enable

    task automatic t_window();
        wr(12'h808, 8'h10);
        wr(12'h809, 8'h10);
        wr(12'h80A, 8'hFF);
        wr(12'h80B, 8'h10);
        wr(12'h80C, 8'h00);
        wr(12'h80D, 8'h20);
        wr(12'h80E, 8'h00);
        wr(12'h80F, 8'h20);
        rd(12'h808, 8'h10, 1'b1, "start0 low");
        rd(12'h809, 8'h10, 1'b1, "start0 high");
        wr(12'h806, 8'h40);
        io(16'h1010, 1'b1, 1'b0, 1'b0, pcw_pkg::CYC_STD, "win0 start");
        io(16'h10FF, 1'b1, 1'b0, 1'b0, pcw_pkg::CYC_STD, "win0 end");
        io(16'h100F, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "below win0");
        io(16'h1100, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "above win0");
        io(16'h2000, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "win1 disabled");
        wr(12'h806, 8'h80);
        io(16'h2000, 1'b1, 1'b1, 1'b0, pcw_pkg::CYC_STD, "win1 single");
        io(16'h1010, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "win0 disabled");
        // Window 1 is stretched down over window 0, which must keep priority where both hit.
        wr(12'h806, 8'hC0);
        wr(12'h80D, 8'h10);
        io(16'h1010, 1'b1, 1'b0, 1'b0, pcw_pkg::CYC_STD, "overlap picks win0");
        io(16'h1008, 1'b1, 1'b1, 1'b0, pcw_pkg::CYC_STD, "win1 below win0");
        wr(12'h80D, 8'h20);
        $display("test window done");
    endtask : t_window

    task automatic t_ctrl();
        logic [3:0] n;
        logic       cw;
        wr(12'h806, 8'hC0);
        for (int k = 0; k < 16; k++) begin
            n = k[3:0];
            // The card pin always disagrees with the fixed width bit of a window that consults it.
            cw = n[0] ^ n[1];
            wantWide = cw;
            wr(12'h807, {~n, n});
            rd(12'h807, {~n, n}, 1'b1, "control readback");
            io(16'h1080, 1'b1, 1'b0, expWide(n, cw), expCyc(n, cw), "win0 timing");
            io(16'h2000, 1'b1, 1'b1, expWide(~n, cw), expCyc(~n, cw), "win1 timing");
        end
        $display("test control done");
    endtask : t_ctrl

    // A second reset in mid-run must wipe what the earlier tests programmed.
    task automatic t_midreset();
        rst = 1'b1;
        step();
        step();
        rst = 1'b0;
        rd(12'h806, 8'h00, 1'b1, "enable after second reset");
        rd(12'h807, 8'h00, 1'b1, "control after second reset");
        rd(12'h808, 8'h00, 1'b1, "start0 after second reset");
        mem(5'h1F, 1'b0, "mem claim after second reset");
        io(16'h1080, 1'b0, 1'b0, 1'b0, pcw_pkg::CYC_STD, "io claim after second reset");
        $display("test second reset done");
    endtask : t_midreset

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_reset();
        t_enable();
        t_window();
        t_ctrl();
        t_midreset();
        end_of_test();
    end
endmodule : pc_card_window_enable_io_control_bench
`default_nettype wire
